// File: sim/core_regfile_stack_irq_tb.sv
// Purpose: self-checking bench of register file, stack and interrupt entry
// Assumes: 40 MHz clock, reset lifts two edges after release
// Notes:   one task per scenario, all values compared with case equality
`timescale 1ns/1ps
module core_regfile_stack_irq_tb;
    logic sys_clk, rst_b, acc_rd = 0, acc_wr = 0, acc_io = 0, go = 0, wr_en = 0, wr_wide = 0;
    logic sp_push1 = 0, sp_pop1 = 0, sp_push2 = 0, sp_pop2 = 0, lo = 0, ptr_go = 0;
    logic [1:0] ptr_sel = 0, ptr_mode = 0;
    logic [5:0] ptr_disp = 0;
    logic [7:0] src_level = 0, flag_clear = 0;
    logic [4:0] rd_addr_a = 0, wr_addr = 0;
    logic [7:0] acc_wdata = 0, src_event = 0, src_enable = 0, rd_data_a, acc_rdata, status_register;
    logic [7:0] irq_flag;
    logic [15:0] wr_data = 0, acc_addr = 0, rd_word_a, stack_pointer, vector_addr, ptr_addr;
    logic acc_hit, vector_valid, irq_busy, insn_done;
    int n_errors = 0, comparisons = 0;
    ////////////////////////////////////////////////////////////////////////////
    exec_model u_exec (.sys_clk, .go, .insn_done);
    core_regfile_stack_irq u_dut (.sys_clk, .rst_b, .rd_addr_a, .rd_addr_b(5'h00), .rd_data_a,
        .rd_data_b(), .rd_word_a, .wr_en, .wr_wide, .wr_addr, .wr_data, .ptr_go,
        .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr, .acc_rd, .acc_wr,
        .acc_io, .acc_addr, .acc_wdata, .acc_rdata, .acc_hit, .prog_ext(lo), .prog_addr(),
        .page_select_bit(), .sp_push1, .sp_pop1, .sp_push2, .sp_pop2, .stack_pointer,
        .stk_wr(), .stk_addr(), .stk_wdata(), .alu_flags_we(lo), .alu_flags(7'h00),
        .status_register, .insn_done, .sei_exec(lo), .cli_exec(lo), .interrupt_return_exec(lo),
        .pc(16'h0200), .src_event, .src_level, .src_enable, .flag_clear, .irq_flag,
        .vector_select_bit(lo), .boot_reset_fuse(lo), .application_lock_bit(lo),
        .boot_lock_bit(lo), .boot_start(16'h0000), .irq_busy, .vector_valid, .vector_addr,
        .reset_vector());
    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task acc(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {acc_io, acc_wr, acc_rd, acc_addr, acc_wdata} <= {io, wr, !wr, a, d};
        @(posedge sys_clk);
        {acc_wr, acc_rd} <= 2'b00;
        #1;
    endtask
    task sp_op(input logic [3:0] k, input logic [15:0] exp);
        @(posedge sys_clk);
        {sp_push1, sp_pop1, sp_push2, sp_pop2} <= k;
        @(posedge sys_clk);
        {sp_push1, sp_pop1, sp_push2, sp_pop2} <= 4'h0;
        #1 chk(stack_pointer, exp);
    endtask
    task t_regs;
        chk(stack_pointer, 16'h0000);
        chk(status_register, 16'h0000);
        acc(1, 1, 16'h003B, 8'hFF);
        acc(0, 0, 16'h005B, 8'h00);
        chk({acc_hit, acc_rdata}, 16'h0101);
        acc(1, 1, 16'h003D, 8'h55);
        acc(0, 1, 16'h005E, 8'h10);
        chk(stack_pointer, 16'h1055);
        acc(0, 0, 16'h0060, 8'h00);
        chk({acc_hit, acc_rdata}, 16'h0000);
        $display("t_regs done");
    endtask
    task t_regfile;
        @(posedge sys_clk);
        {wr_en, wr_wide, wr_addr, wr_data, rd_addr_a} <= {2'b11, 5'h1A, 16'h1234, 5'h1A};
        @(posedge sys_clk);
        wr_en <= 0;
        #1 chk(rd_word_a, 16'h1234);
        rd_addr_a <= 5'h1B;
        #1 chk(rd_data_a, 16'h0012);
        acc(0, 0, 16'h001A, 8'h00);
        chk(acc_rdata, 16'h0034);
        $display("t_regfile done");
    endtask
    // pair 26/27 holds 0x1234 here: post-inc, then pre-dec, then displacement
    task t_ptr;
        @(posedge sys_clk);
        {ptr_go, ptr_sel, ptr_mode, ptr_disp} <= {1'b1, 2'h0, 2'h1, 6'h05};
        @(posedge sys_clk);
        ptr_mode <= 2'h2;
        #1 chk(ptr_addr, 16'h1234);
        chk(rd_word_a, 16'h1235);
        @(posedge sys_clk);
        ptr_mode <= 2'h3;
        #1 chk(ptr_addr, 16'h1234);
        chk(rd_word_a, 16'h1234);
        @(posedge sys_clk);
        ptr_go <= 0;
        #1 chk(ptr_addr, 16'h1239);
        chk(rd_word_a, 16'h1234);
        $display("t_ptr done");
    endtask
    task t_stack;
        sp_op(4'b0010, 16'h1053);
        sp_op(4'b1000, 16'h1052);
        sp_op(4'b0100, 16'h1053);
        sp_op(4'b0001, 16'h1055);
        $display("t_stack done");
    endtask
    // sets global enable, completes one instruction, then judges the entry
    task take_irq(input logic [15:0] exp_vec, input logic [15:0] exp_sp);
        int n;
        acc(0, 1, 16'h005F, 8'h80);
        @(posedge sys_clk);
        go <= 1;
        @(posedge sys_clk);
        go <= 0;
        n = 0;
        while (vector_valid !== 1'b1 && n < 12) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 12) n_errors++;
        chk(16'(n), 16'h0004);
        chk(vector_addr, exp_vec);
        chk(status_register[7], 16'h0000);
        chk(stack_pointer, exp_sp);
    endtask
    task t_irq;
        @(posedge sys_clk);
        {src_enable, src_event} <= {8'h06, 8'h06};
        @(posedge sys_clk);
        {src_event, go} <= {8'h00, 1'b1};
        @(posedge sys_clk);
        go <= 0;
        repeat (3) @(posedge sys_clk);
        #1 chk(irq_busy, 16'h0000);
        chk(irq_flag, 16'h0006);
        // stack pointer already loaded before enabling
        take_irq(16'h0004, 16'h1053);
        chk(irq_flag, 16'h0004);
        @(posedge sys_clk);
        flag_clear <= 8'h04;
        @(posedge sys_clk);
        {flag_clear, src_level, src_enable} <= {8'h00, 8'h40, 8'h40};
        #1 chk(irq_flag, 16'h0000);
        // condition source 6 has no flag and vectors at (6+1)*2
        take_irq(16'h000E, 16'h1051);
        $display("t_irq done");
    endtask
    initial begin
        rst_b = 0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1;
        repeat (4) @(posedge sys_clk);
        #1;
        t_regs;
        t_regfile;
        t_ptr;
        t_stack;
        t_irq;
        final_report;
    end
endmodule

// File: sim/exec_model.sv
// Purpose: executor stand-in that completes one instruction per request
// Assumes: go is a one-cycle request from the bench
// Notes:   never issues stack operations, so entry pushes are never disturbed
`timescale 1ns/1ps
module exec_model (
    input  wire logic sys_clk,
    input  wire logic go,
    output logic      insn_done
);
    // single-cycle completion, one pulse per instruction
    always_ff @(posedge sys_clk) begin
        insn_done <= go;
    end
endmodule

// File: verilog/core_pkg.sv
// Purpose: shared constants and types of the core register file, stack and interrupt block
// Assumes: one undivided core clock, I/O offsets as seen by I/O-space instructions
// Notes:   data-space address of an I/O register is its offset plus io_offset
package core_pkg;
    localparam int          clk_period_ns    = 25;
    localparam logic [15:0] io_offset        = 16'h0020;
    localparam logic [15:0] rf_last_addr     = 16'h001F;
    localparam logic [5:0]  io_page_select   = 6'h3B;
    localparam logic [5:0]  io_sp_low        = 6'h3D;
    localparam logic [5:0]  io_sp_high       = 6'h3E;
    localparam logic [5:0]  io_status        = 6'h3F;
    localparam logic [7:0]  reg_reset        = 8'h00;
    localparam logic [15:0] sp_reset         = 16'h0000;
    localparam logic [15:0] reset_vec_low    = 16'h0000;
    localparam logic [4:0]  ptr_first_idx    = 5'h1A;
    localparam int          gie_bit          = 7;
    localparam int          page_bit_pos     = 0;
    localparam int          num_src          = 8;
    // sources 6 and 7 are condition-based, the rest latch a flag
    localparam logic [7:0]  level_src_mask   = 8'hC0;
    localparam logic [15:0] vec_spacing      = 16'h0002;
    localparam logic [15:0] sp_step_byte     = 16'h0001;
    localparam logic [15:0] sp_step_addr     = 16'h0002;
    localparam logic [15:0] ptr_step         = 16'h0001;

    typedef enum logic [1:0] {
        ptr_plain   = 2'b00,
        ptr_postinc = 2'b01,
        ptr_predec  = 2'b10,
        ptr_disp    = 2'b11
    } ptr_mode_type;

    typedef enum logic [1:0] {
        entry_idle    = 2'b00,
        entry_push_hi = 2'b01,
        entry_wait_a  = 2'b10,
        entry_wait_b  = 2'b11
    } entry_state_type;
endpackage

// File: verilog/core_regfile_stack_irq.sv
// Purpose: register file, pointers, stack pointer, page select and interrupt entry of the core
// Assumes: executor pulses one-cycle strobes, insn_done marks each completed instruction
// Notes:   i/o registers answer at offset (io access) and offset plus io_offset (data access)
`timescale 1ns/1ps
module core_regfile_stack_irq (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // register file ports of the executor
    input  wire logic [4:0]  rd_addr_a,
    input  wire logic [4:0]  rd_addr_b,
    output logic      [7:0]  rd_data_a,
    output logic      [7:0]  rd_data_b,
    output logic      [15:0] rd_word_a,
    input  wire logic        wr_en,
    input  wire logic        wr_wide,
    input  wire logic [4:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    // pointer addressing
    input  wire logic        ptr_go,
    input  wire logic [1:0]  ptr_sel,
    input  wire logic [1:0]  ptr_mode,
    input  wire logic [5:0]  ptr_disp,
    output logic      [15:0] ptr_addr,
    // data-space and i/o-space access
    input  wire logic        acc_rd,
    input  wire logic        acc_wr,
    input  wire logic        acc_io,
    input  wire logic [15:0] acc_addr,
    input  wire logic [7:0]  acc_wdata,
    output logic      [7:0]  acc_rdata,
    output logic             acc_hit,
    // program-memory load address
    input  wire logic        prog_ext,
    output logic      [16:0] prog_addr,
    output logic             page_select_bit,
    // stack
    input  wire logic        sp_push1,
    input  wire logic        sp_pop1,
    input  wire logic        sp_push2,
    input  wire logic        sp_pop2,
    output logic      [15:0] stack_pointer,
    output logic             stk_wr,
    output logic      [15:0] stk_addr,
    output logic      [7:0]  stk_wdata,
    // status and instruction events
    input  wire logic        alu_flags_we,
    input  wire logic [6:0]  alu_flags,
    output logic      [7:0]  status_register,
    input  wire logic        insn_done,
    input  wire logic        sei_exec,
    input  wire logic        cli_exec,
    input  wire logic        interrupt_return_exec,
    input  wire logic [15:0] pc,
    // interrupt sources and vectoring
    input  wire logic [7:0]  src_event,
    input  wire logic [7:0]  src_level,
    input  wire logic [7:0]  src_enable,
    input  wire logic [7:0]  flag_clear,
    output logic      [7:0]  irq_flag,
    input  wire logic        vector_select_bit,
    input  wire logic        boot_reset_fuse,
    input  wire logic        application_lock_bit,
    input  wire logic        boot_lock_bit,
    input  wire logic [15:0] boot_start,
    output logic             irq_busy,
    output logic             vector_valid,
    output logic      [15:0] vector_addr,
    output logic      [15:0] reset_vector
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic io_hit(input logic [15:0] a, input logic [5:0] off);
        io_hit = (a == ({10'h000, off} + core_pkg::io_offset));
    endfunction

    function automatic logic [2:0] first_set(input logic [7:0] v);
        first_set = 3'h0;
        for (int i = core_pkg::num_src - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic                        gie;
    logic [6:0]                  flags;
    logic [15:0]                 sp;
    logic                        page_bit;
    logic [15:0]                 ret_pc;
    core_pkg::entry_state_type   state;
    core_pkg::entry_state_type   next_state;
    logic [7:0]                  rd_data_c;
    logic [47:0]                 ptr_words;

    wire [15:0] acc_eff  = acc_io ? ({10'h000, acc_addr[5:0]} + core_pkg::io_offset)
                                  : acc_addr;
    wire        hit_rf   = acc_eff <= core_pkg::rf_last_addr;
    wire        hit_page = io_hit(acc_eff, core_pkg::io_page_select);
    wire        hit_spl  = io_hit(acc_eff, core_pkg::io_sp_low);
    wire        hit_sph  = io_hit(acc_eff, core_pkg::io_sp_high);
    wire        hit_sts  = io_hit(acc_eff, core_pkg::io_status);
    wire        hit_any  = hit_rf | hit_page | hit_spl | hit_sph | hit_sts;
    wire        rf_ds_wr = acc_wr && hit_rf && !wr_en;

    ////////////////////////////////////////////////////////////////////////////
    // pointer addressing; the update uses the dedicated pointer write port
    wire [15:0] cur_ptr  = ptr_words[{ptr_sel, 4'h0} +: 16];
    wire [15:0] ptr_inc  = cur_ptr + core_pkg::ptr_step;
    wire [15:0] ptr_dec  = cur_ptr - core_pkg::ptr_step;
    wire        ptr_upd  = ptr_go && (ptr_mode == core_pkg::ptr_postinc ||
                                      ptr_mode == core_pkg::ptr_predec);
    wire [4:0]  ptr_idx  = core_pkg::ptr_first_idx + {2'b00, ptr_sel, 1'b0};
    wire [15:0] ptr_new  = (ptr_mode == core_pkg::ptr_postinc) ? ptr_inc : ptr_dec;
    wire [15:0] ptr_eff  = (ptr_mode == core_pkg::ptr_predec) ? ptr_dec :
                           (ptr_mode == core_pkg::ptr_disp)
                               ? cur_ptr + {10'h000, ptr_disp} : cur_ptr;

    gpr_file u_gpr (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .rd_addr_a   (rd_addr_a),
        .rd_addr_b   (rd_addr_b),
        .rd_addr_c   (acc_eff[4:0]),
        .rd_data_a   (rd_data_a),
        .rd_data_b   (rd_data_b),
        .rd_data_c   (rd_data_c),
        .rd_word_a   (rd_word_a),
        .ptr_words   (ptr_words),
        .wr_en       (wr_en | rf_ds_wr),
        .wr_wide     (wr_en & wr_wide),
        .wr_addr     (wr_en ? wr_addr : acc_eff[4:0]),
        .wr_data     (wr_en ? wr_data : {8'h00, acc_wdata}),
        .ptr_wr_en   (ptr_upd),
        .ptr_wr_idx  (ptr_idx),
        .ptr_wr_data (ptr_new)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt request and arbitration
    wire [7:0] flag_set   = src_event & ~core_pkg::level_src_mask;
    wire [7:0] cond_req   = src_level & core_pkg::level_src_mask;
    wire [7:0] irq_req    = (irq_flag | cond_req) & src_enable;
    wire [2:0] irq_idx    = first_set(irq_req);
    // a vector outside the running section is locked while the code runs there and that section's lock bit is set
    wire       in_boot    = pc >= boot_start;
    wire       irq_locked = (application_lock_bit && !in_boot && vector_select_bit) ||
                            (boot_lock_bit && in_boot && !vector_select_bit);
    // entry waits for a completing insn that is not sei, cli or interrupt_return, so exactly one more runs
    wire       irq_take   = gie && (|irq_req) && insn_done &&
                            !cli_exec && !sei_exec && !interrupt_return_exec && !irq_locked &&
                            state == core_pkg::entry_idle;
    wire [7:0] take_mask  = irq_take ? (8'h01 << irq_idx) : 8'h00;
    wire [7:0] next_flag  = (irq_flag & ~flag_clear & ~take_mask) | flag_set;
    wire [15:0] vec_base  = vector_select_bit ? boot_start : core_pkg::reset_vec_low;
    wire [15:0] next_vec  = vec_base + ({13'h0000, irq_idx} + core_pkg::sp_step_byte) *
                            core_pkg::vec_spacing;
    wire       sts_wr     = acc_wr && hit_sts;
    wire       next_gie   = irq_take ? 1'b0 :
                            cli_exec ? 1'b0 :
                            (sei_exec || interrupt_return_exec) ? 1'b1 :
                            sts_wr ? acc_wdata[core_pkg::gie_bit] : gie;

    ////////////////////////////////////////////////////////////////////////////
    // entry sequence: two return-address pushes, then two cycles to the vector
    always_comb begin
        next_state = state;
        case (state)
            core_pkg::entry_idle:    next_state = irq_take ? core_pkg::entry_push_hi
                                                           : core_pkg::entry_idle;
            core_pkg::entry_push_hi: next_state = core_pkg::entry_wait_a;
            core_pkg::entry_wait_a:  next_state = core_pkg::entry_wait_b;
            default:                 next_state = core_pkg::entry_idle;
        endcase
    end

    wire push_now = irq_take || state == core_pkg::entry_push_hi;

    logic [15:0] next_sp;
    always_comb begin
        next_sp = sp;
        if (push_now) begin
            next_sp = sp - core_pkg::sp_step_byte;
        end else if (sp_push1) begin
            next_sp = sp - core_pkg::sp_step_byte;
        end else if (sp_pop1) begin
            next_sp = sp + core_pkg::sp_step_byte;
        end else if (sp_push2) begin
            next_sp = sp - core_pkg::sp_step_addr;
        end else if (sp_pop2) begin
            next_sp = sp + core_pkg::sp_step_addr;
        end
        if (acc_wr && hit_spl) begin
            next_sp[7:0] = acc_wdata;
        end
        if (acc_wr && hit_sph) begin
            next_sp[15:8] = acc_wdata;
        end
    end

    wire [7:0] next_rdata = hit_rf   ? rd_data_c :
                            hit_page ? {7'h00, page_bit} :
                            hit_spl  ? sp[7:0] :
                            hit_sph  ? sp[15:8] :
                            hit_sts  ? {gie, flags} : core_pkg::reg_reset;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= core_pkg::entry_idle;
            gie   <= 1'b0;
            flags <= 7'h00;
            sp    <= core_pkg::sp_reset;
        end else begin
            state <= next_state;
            gie   <= next_gie;
            sp    <= next_sp;
            // hardware never stacks the flags around an interrupt
            if (sts_wr) begin
                flags <= acc_wdata[6:0];
            end else if (alu_flags_we) begin
                flags <= alu_flags;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag    <= 8'h00;
            page_bit    <= 1'b0;
            ret_pc      <= 16'h0000;
        end else begin
            irq_flag <= next_flag;
            if (acc_wr && hit_page) begin
                page_bit <= acc_wdata[core_pkg::page_bit_pos];
            end
            if (irq_take) begin
                ret_pc <= pc;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stk_wr       <= 1'b0;
            stk_addr     <= 16'h0000;
            stk_wdata    <= 8'h00;
            vector_valid <= 1'b0;
            vector_addr  <= 16'h0000;
            irq_busy     <= 1'b0;
        end else begin
            stk_wr       <= push_now;
            stk_addr     <= sp;
            stk_wdata    <= irq_take ? pc[7:0] : ret_pc[15:8];
            vector_valid <= state == core_pkg::entry_wait_b;
            irq_busy     <= next_state != core_pkg::entry_idle;
            if (irq_take) begin
                vector_addr <= next_vec;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_rdata       <= 8'h00;
            acc_hit         <= 1'b0;
            ptr_addr        <= 16'h0000;
            prog_addr       <= 17'h00000;
            page_select_bit <= 1'b0;
            stack_pointer   <= core_pkg::sp_reset;
            status_register <= core_pkg::reg_reset;
            reset_vector    <= core_pkg::reset_vec_low;
        end else begin
            acc_rdata       <= next_rdata;
            acc_hit         <= (acc_rd || acc_wr) && hit_any;
            ptr_addr        <= ptr_go ? ptr_eff : ptr_addr;
            // plain loads see only the low 64K
            prog_addr       <= {prog_ext & page_bit, ptr_words[47:32]};
            page_select_bit <= page_bit;
            stack_pointer   <= next_sp;
            status_register <= {next_gie, flags};
            reset_vector    <= boot_reset_fuse ? boot_start : core_pkg::reset_vec_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_TAKE_NEEDS_ENABLES: assert property (irq_take |-> gie && (irq_req != 8'h00))
        else $error("interrupt taken without enables");
    AST_CLI_SAME_CYCLE: assert property (cli_exec |-> !irq_take)
        else $error("interrupt taken with global disable");
    AST_ENTRY_CLEARS_GIE: assert property (irq_take |=> !gie && irq_busy)
        else $error("global enable not cleared on entry");
    AST_VECTOR_TIMING: assert property (irq_take |-> !vector_valid [*4] ##1 vector_valid)
        else $error("vector not presented four cycles after entry");
    AST_ENTRY_SP: assert property (irq_take && !acc_wr |-> ##2 sp == $past(sp, 2) - 16'h0002)
        else $error("entry did not drop stack pointer by two");
    AST_PUSH1: assert property (sp_push1 && !push_now && !acc_wr |=> sp == $past(sp) - 16'h0001)
        else $error("byte push did not decrement by one");
    AST_POP2: assert property (sp_pop2 && !push_now && !sp_push1 && !sp_pop1 && !sp_push2
                               && !acc_wr |=> sp == $past(sp) + 16'h0002)
        else $error("return pop did not increment by two");
    AST_INTERRUPT_RETURN_GIE: assert property (interrupt_return_exec |=> gie)
        else $error("return did not set global enable");
    AST_ONE_AFTER_INTERRUPT_RETURN: assert property (interrupt_return_exec |=> !irq_busy)
        else $error("interrupt served straight after return");
    AST_PRIORITY: assert property (irq_take |-> (irq_req & ((8'h01 << irq_idx) - 8'h01)) == 8'h00)
        else $error("lower priority source served first");
    AST_FLAG_CLEAR: assert property (irq_take && ((flag_set & take_mask) == 8'h00)
                                     |=> (irq_flag & $past(take_mask)) == 8'h00)
        else $error("flag not cleared on vectoring");
    AST_PAGE_HIGH_ZERO: assert property (acc_rd && hit_page |=> acc_rdata[7:1] == 7'h00)
        else $error("unused page bits read nonzero");

    COV_TAKE: cover property (irq_take ##4 vector_valid);
    COV_NESTED: cover property (irq_busy ##1 sei_exec ##[1:20] irq_take);
    COV_INTERRUPT_RETURN_PENDING: cover property (interrupt_return_exec && irq_req != 8'h00 ##2 irq_take);
    COV_POSTINC: cover property (ptr_go && ptr_mode == core_pkg::ptr_postinc);
endmodule

// File: verilog/gpr_file.sv
// Purpose: 32 x 8 working register file with pointer write port
// Assumes: caller never writes the same byte from both ports in one cycle
// Notes:   reads are combinational so an operate-and-write fits one cycle
`timescale 1ns/1ps
module gpr_file (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  rd_addr_a,
    input  wire logic [4:0]  rd_addr_b,
    input  wire logic [4:0]  rd_addr_c,
    output logic      [7:0]  rd_data_a,
    output logic      [7:0]  rd_data_b,
    output logic      [7:0]  rd_data_c,
    output logic      [15:0] rd_word_a,
    output logic      [47:0] ptr_words,
    input  wire logic        wr_en,
    input  wire logic        wr_wide,
    input  wire logic [4:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        ptr_wr_en,
    input  wire logic [4:0]  ptr_wr_idx,
    input  wire logic [15:0] ptr_wr_data
);
    logic [7:0] rf [0:31];
    wire  [4:0] a_even  = {rd_addr_a[4:1], 1'b0};
    wire  [4:0] a_odd   = {rd_addr_a[4:1], 1'b1};
    wire  [4:0] w_even  = {wr_addr[4:1], 1'b0};
    wire  [4:0] w_odd   = {wr_addr[4:1], 1'b1};
    wire  [4:0] p_odd   = {ptr_wr_idx[4:1], 1'b1};

    assign rd_data_a = rf[rd_addr_a];
    assign rd_data_b = rf[rd_addr_b];
    assign rd_data_c = rf[rd_addr_c];
    assign rd_word_a = {rf[a_odd], rf[a_even]};
    assign ptr_words = {rf[31], rf[30], rf[29], rf[28], rf[27], rf[26]};

    // later assignment wins, so an instruction write beats a pointer update
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                rf[i] <= core_pkg::reg_reset;
            end
        end else begin
            if (ptr_wr_en) begin
                rf[{ptr_wr_idx[4:1], 1'b0}] <= ptr_wr_data[7:0];
                rf[p_odd]                   <= ptr_wr_data[15:8];
            end
            if (wr_en && wr_wide) begin
                rf[w_even] <= wr_data[7:0];
                rf[w_odd]  <= wr_data[15:8];
            end else if (wr_en) begin
                rf[wr_addr] <= wr_data[7:0];
            end
        end
    end
endmodule
